// file: bench/usb2_phy_model.sv
// usb 2.0 phy and general purpose pin model facing the tuning register bank
`timescale 1ns/1ns
module usb2_phy_model
    import usb3_tuning_pkg::*;
(
    // clock and phy controls from the bank
    input logic ref_clk,
    input usb3_tuning_pkg::l1_phy_s l1_phy,
    // pin level chosen by the bench
    input logic [15:0] pin_level,
    output logic [15:0] general_input_port,
    output logic low_power_q
);
    // pins follow the chosen level; the bank does its own synchronising
    assign general_input_port = pin_level;
    // phy rests in low power while either suspend request is up
    always_ff @(posedge ref_clk)
    begin
        low_power_q <= l1_phy.phy_deep_suspend_out | l1_phy.phy_sleep_out;
    end
endmodule // usb2_phy_model

// file: bench/usb3_global_tuning_registers_tb_top.sv
// self-checking bench for the global tuning register bank
`timescale 1ns/1ns
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin n_fail++; $display("ERROR %0t got %h exp %h", $time, a, b); end end
module usb3_global_tuning_registers_tb_top;
    import usb3_tuning_pkg::*;
    // --------------------------------------------------------------
    // stimulus and observation
    // --------------------------------------------------------------
    logic ref_clk = 0, rst = 1, reg_wr = 0, reg_rd = 0, host_mode = 1, l1_active = 1;
    logic [15:0] reg_addr = 0, pin_level = 16'h1234, general_input_port, general_output_port;
    logic [31:0] reg_wdata = 0, reg_rdata;
    logic [3:0] hird_in_use = 4'h8;
    logic frame_start = 0, babble_check = 0, babble_seen = 0, ctx_check_req = 0, ctx_fields_bad = 0;
    logic address_cmd = 0, first_packet_ok, babble_port_disable, ctx_param_error, addr_valid, low_power;
    logic [7:0] slot_id = 8'h09, device_address;
    sched_ctrl_s sched_ctrl;
    l1_phy_s l1_phy;
    int n_fail = 0, compares = 0, cycles = 0, n_babble = 0, n_ctx = 0, n_addr = 0;
    usb3_tuning_regs u_usb3_tuning_regs (.ref_clk(ref_clk), .rst(rst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .host_mode(host_mode), .l1_active(l1_active), .hird_in_use(hird_in_use),
        .frame_start(frame_start), .babble_check(babble_check), .babble_seen(babble_seen),
        .ctx_check_req(ctx_check_req), .ctx_fields_bad(ctx_fields_bad), .address_cmd(address_cmd),
        .slot_id(slot_id), .sched_ctrl(sched_ctrl), .l1_phy(l1_phy), .first_packet_ok(first_packet_ok),
        .babble_port_disable(babble_port_disable), .ctx_param_error(ctx_param_error),
        .addr_valid(addr_valid), .device_address(device_address),
        .general_input_port(general_input_port), .general_output_port(general_output_port));
    usb2_phy_model u_usb2_phy_model (.ref_clk(ref_clk), .l1_phy(l1_phy), .pin_level(pin_level),
        .general_input_port(general_input_port), .low_power_q(low_power));
    // 100 mhz clock
    initial
    begin
        forever #5 ref_clk = ~ref_clk;
    end
    // --------------------------------------------------------------
    // pulse counters and hang guard
    // --------------------------------------------------------------
    always @(posedge ref_clk)
    begin
        cycles++;
        if (babble_port_disable === 1'b1) n_babble++;
        if (ctx_param_error === 1'b1) n_ctx++;
        if (addr_valid === 1'b1) n_addr++;
        if (cycles == 5000)
        begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask
    // one-cycle write strobe beside address and data
    task automatic wr(input logic [15:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
    endtask
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [31:0] exp);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 `CHK(reg_rdata, exp)
    endtask
    // let derived outputs settle
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic babble(input logic seen);
        @(posedge ref_clk);
        babble_check <= 1'b1;
        babble_seen <= seen;
    endtask
    task automatic ev(input logic addr_not_ctx);
        @(posedge ref_clk);
        address_cmd <= addr_not_ctx;
        ctx_check_req <= ~addr_not_ctx;
        ctx_fields_bad <= 1'b1;
        @(posedge ref_clk);
        address_cmd <= 1'b0;
        ctx_check_req <= 1'b0;
        tick(2);
    endtask
    // --------------------------------------------------------------
    // main sequence
    // --------------------------------------------------------------
    initial
    begin
        repeat (5) @(posedge ref_clk);
        rst <= 1'b0;
        rd(ADDR_CONTROL_SECONDARY, SEC_RESET);
        rd(ADDR_CONTROL_PRIMARY, PRI_RESET);
        rd(ADDR_USER_TAG, USER_TAG_RESET);
        rd(ADDR_CORE_IDENTITY, {CORE_ID_DEFAULT, RELEASE_DEFAULT});
        `CHK({sched_ctrl.hs_packets_per_request, sched_ctrl.hs_nak_limit}, {PARK_PACKETS, PARK_NAK_LIMIT})
        `CHK(sched_ctrl.hs_nak_async_boost, 1'b1)
        // hird at threshold: deep; one below: sleep, common mirrors sleep
        tick(2);
        `CHK({l1_phy, low_power}, 4'b1001)
        @(posedge ref_clk) hird_in_use <= 4'h7;
        tick(2);
        `CHK(l1_phy, 3'b011)
        // gpio: upper half drives pins out, lower half reads pins in
        wr(ADDR_GENERAL_PURPOSE_IO, 32'hABCD_FFFF);
        tick(2);
        `CHK(general_output_port, 16'hABCD)
        rd(ADDR_GENERAL_PURPOSE_IO, 32'hABCD_1234);
        wr(ADDR_USER_TAG, 32'hCAFE_0001);
        rd(ADDR_USER_TAG, 32'hCAFE_0001);
        // park off on all speeds with the babble filter on; exit latency bit stays set
        wr(ADDR_CONTROL_SECONDARY, SEC_RESET | 32'h0003_8001);
        tick(2);
        `CHK({sched_ctrl.ss_park_off, sched_ctrl.hs_park_off, sched_ctrl.fsls_park_off}, 3'b111)
        `CHK({sched_ctrl.hs_packets_per_request, sched_ctrl.hs_nak_limit}, {SINGLE_PACKET, SINGLE_NAK_LIMIT})
        // two hits, a clean check, then three hits: one disable only
        babble(1);
        babble(1);
        babble(0);
        babble(1);
        babble(1);
        `CHK(n_babble, 0)
        babble(1);
        @(posedge ref_clk) babble_check <= 1'b0;
        tick(3);
        `CHK(n_babble, 1)
        // context violation reported while checking is on
        ev(1'b0);
        `CHK(n_ctx, 1)
        ev(1'b1);
        `CHK(device_address, 8'h01)
        ev(1'b1);
        `CHK(device_address, 8'h02)
        // threshold off: sleep even at the top hird; context checking off
        wr(ADDR_CONTROL_SECONDARY, 32'h0004_008E);
        hird_in_use <= 4'hF;
        tick(2);
        `CHK(l1_phy, 3'b011)
        `CHK({sched_ctrl.exit_latency_delta_enable, sched_ctrl.context_check_off}, 2'b11)
        ev(1'b0);
        `CHK(n_ctx, 1)
        // frame wait holds the first packet back for two microseconds
        @(posedge ref_clk) frame_start <= 1'b1;
        @(posedge ref_clk) frame_start <= 1'b0;
        tick(195);
        `CHK(first_packet_ok, 1'b0)
        tick(10);
        `CHK(first_packet_ok, 1'b1)
        // period written as 62 ns and kept as written; reserved bits ignored
        wr(ADDR_CONTROL_PRIMARY, 32'h0FBF_7FFF);
        rd(ADDR_CONTROL_PRIMARY, 32'h0FA3_0000);
        `CHK({sched_ctrl.ref_period_ns, sched_ctrl.periodic_share_pct}, {10'h03E, PERIODIC_SHARE_HIGH})
        `CHK({sched_ctrl.skip_post_frame_wait, sched_ctrl.sparse_control_schedule}, 2'b11)
        @(posedge ref_clk) frame_start <= 1'b1;
        @(posedge ref_clk) frame_start <= 1'b0;
        tick(3);
        `CHK(first_packet_ok, 1'b1)
        ev(1'b1);
        `CHK({device_address, n_addr[7:0]}, {8'h09, 8'h03})
        wr(ADDR_CONTROL_SECONDARY, 32'hFFFF_FFFF);
        rd(ADDR_CONTROL_SECONDARY, SEC_WRITE_MASK);
        wr(16'hC130, 32'hFFFF_FFFF);
        rd(16'hC130, 32'h0000_0000);
        // device mode: park and relaxed reserve controls fall away
        @(posedge ref_clk) host_mode <= 1'b0;
        tick(2);
        `CHK({sched_ctrl.ss_park_off, sched_ctrl.hs_park_off, sched_ctrl.fsls_park_off}, 3'b000)
        `CHK(sched_ctrl.periodic_share_pct, PERIODIC_SHARE_LOW)
        test_done();
    end
endmodule // usb3_global_tuning_registers_tb_top

// file: src/usb3_tuning_pkg.sv
// constants, register map and carrier types of the global tuning register bank
package usb3_tuning_pkg;

    // --------------------------------------------------------------
    // register byte addresses
    // --------------------------------------------------------------
    localparam logic [15:0] ADDR_CONTROL_SECONDARY = 16'hC11C;
    localparam logic [15:0] ADDR_CORE_IDENTITY = 16'hC120;
    localparam logic [15:0] ADDR_GENERAL_PURPOSE_IO = 16'hC124;
    localparam logic [15:0] ADDR_USER_TAG = 16'hC128;
    localparam logic [15:0] ADDR_CONTROL_PRIMARY = 16'hC12C;

    // --------------------------------------------------------------
    // secondary control: field positions, writable mask, reset value
    // --------------------------------------------------------------
    localparam int SEC_HS_NAK_BOOST = 18;
    localparam int SEC_SS_PARK_OFF = 17;
    localparam int SEC_HS_PARK_OFF = 16;
    localparam int SEC_FSLS_PARK_OFF = 15;
    localparam int SEC_THR_ENABLE = 8;
    localparam int SEC_THR_LSB = 4;
    localparam int SEC_ELD_ENABLE = 3;
    localparam int SEC_CTX_CHECK_OFF = 2;
    localparam int SEC_COMMON_FOLLOWS_SLEEP = 1;
    localparam int SEC_BABBLE_FILTER = 0;
    localparam logic [31:0] SEC_WRITE_MASK = 32'h0007_81FF;
    localparam logic [31:0] SEC_RESET = 32'h0004_018A;

    // --------------------------------------------------------------
    // primary control: field positions, writable mask, reset value
    // --------------------------------------------------------------
    localparam int PRI_REF_PERIOD_LSB = 22;
    localparam int PRI_SKIP_FRAME_WAIT = 21;
    localparam int PRI_SPARSE_CONTROL = 17;
    localparam int PRI_BANDWIDTH_85 = 16;
    localparam int PRI_ADDR_COMPLIANCE = 15;
    localparam logic [31:0] PRI_WRITE_MASK = 32'hFFE3_8000;
    localparam logic [31:0] PRI_RESET = 32'h0200_8000;

    // --------------------------------------------------------------
    // other reset values and identity
    // --------------------------------------------------------------
    localparam logic [31:0] USER_TAG_RESET = 32'h1234_5678;
    localparam logic [15:0] GPO_RESET = 16'h0000;
    localparam logic [15:0] CORE_ID_DEFAULT = 16'hA5C3;  // arbitrary value
    localparam logic [15:0] RELEASE_DEFAULT = 16'h0101;  // arbitrary value

    // --------------------------------------------------------------
    // scheduler figures and timing
    // --------------------------------------------------------------
    localparam logic [2:0] PARK_PACKETS = 3'h4;
    localparam logic [2:0] SINGLE_PACKET = 3'h1;
    localparam logic [3:0] PARK_NAK_LIMIT = 4'h3;
    localparam logic [3:0] SINGLE_NAK_LIMIT = 4'hC;
    localparam logic [6:0] PERIODIC_SHARE_LOW = 7'h50;   // 80 percent
    localparam logic [6:0] PERIODIC_SHARE_HIGH = 7'h55;  // 85 percent
    localparam logic [1:0] BABBLE_REPEATS = 2'h3;
    localparam int CLK_PERIOD_NS = 10;
    localparam int FRAME_WAIT_NS = 2000;
    localparam int FRAME_WAIT_CYC = (FRAME_WAIT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // scheduler controls handed to the host engine
    typedef struct packed {
        logic ss_park_off;
        logic hs_park_off;
        logic fsls_park_off;
        logic hs_nak_async_boost;
        logic skip_post_frame_wait;
        logic sparse_control_schedule;
        logic exit_latency_delta_enable;
        logic context_check_off;
        logic [2:0] hs_packets_per_request;
        logic [3:0] hs_nak_limit;
        logic [6:0] periodic_share_pct;
        logic [9:0] ref_period_ns;
    } sched_ctrl_s;

    // low-power signalling toward the phy, all active high
    typedef struct packed {
        logic phy_deep_suspend_out;
        logic phy_sleep_out;
        logic phy_suspend_common_out;
    } l1_phy_s;

endpackage

// file: src/usb3_tuning_regs.sv
// global tuning, identity and general purpose register bank with its host-side effects
`timescale 1ns/1ns
// Summary of operation
// - superspeed park off in host mode
// - park mode: four-packet requests, three naks
// - park off: single packet, twelve naks
// - full/low speed park off in host mode
// - high speed nak boost, resets on
// - deep suspend when enabled and hird at or above threshold
// - sleep when hird below or threshold disabled
// - threshold bits 7:4 reset eight, enable resets one
// - exit latency delta bit resets set
// - context check raises parameter error unless disabled
// - suspend common follows sleep when overload set
// - babble filter needs three consecutive detections
// - gpio upper half drives output port
// - gpio lower half reads input port
// - user tag writable, resets 12345678
// - identity holds core id and release
// - two microsecond wait after frame start
// - sparse control transfers across microframes
// - periodic reserve 80 or 85 percent
// - address increments or equals slot id
module usb3_tuning_regs
    import usb3_tuning_pkg::*;
#(
    parameter logic [15:0] CORE_ID = CORE_ID_DEFAULT,
    parameter logic [15:0] RELEASE_ID = RELEASE_DEFAULT
)
(
    // clock and reset
    input logic ref_clk,
    input logic rst,
    // register port
    input logic [15:0] reg_addr,
    input logic [31:0] reg_wdata,
    input logic reg_wr,
    input logic reg_rd,
    output logic [31:0] reg_rdata,
    // controller state
    input logic host_mode,
    input logic l1_active,
    input logic [3:0] hird_in_use,
    // host engine events
    input logic frame_start,
    input logic babble_check,
    input logic babble_seen,
    input logic ctx_check_req,
    input logic ctx_fields_bad,
    input logic address_cmd,
    input logic [7:0] slot_id,
    // host engine answers
    output usb3_tuning_pkg::sched_ctrl_s sched_ctrl,
    output usb3_tuning_pkg::l1_phy_s l1_phy,
    output logic first_packet_ok,
    output logic babble_port_disable,
    output logic ctx_param_error,
    output logic addr_valid,
    output logic [7:0] device_address,
    // general purpose pins
    input logic [15:0] general_input_port,
    output logic [15:0] general_output_port
);
    import usb3_tuning_pkg::*;

    // ----------------------------------------------------------------
    // decoding helpers
    // ----------------------------------------------------------------
    // babble detections needed before a port is dropped
    function automatic logic [1:0] babble_needed(input logic filter_on);
        babble_needed = filter_on ? BABBLE_REPEATS : 2'h1;
    endfunction

    // true when the hird value asks for the deep state
    function automatic logic deep_wanted(input logic en, input logic [3:0] hird, input logic [3:0] thr);
        deep_wanted = en && (hird >= thr);
    endfunction

    // ----------------------------------------------------------------
    // storage
    // ----------------------------------------------------------------
    logic [31:0] sec_q;      // secondary control
    logic [31:0] pri_q;      // primary control
    logic [31:0] tag_q;      // user tag
    logic [15:0] gpo_q;      // general output field
    logic [15:0] gpi_meta_q; // first synchroniser stage
    logic [15:0] gpi_q;      // second synchroniser stage
    logic [31:0] rdata_q;
    logic [7:0] wait_cnt_q;  // cycles left of the post-frame wait
    logic [1:0] babble_cnt_q;
    logic [6:0] next_addr_q; // next address handed out in compliance mode
    sched_ctrl_s sched_q;
    l1_phy_s l1_q;
    logic first_ok_q;
    logic babble_dis_q;
    logic ctx_err_q;
    logic addr_valid_q;
    logic [7:0] dev_addr_q;
    logic deep_d;            // deep state requested this cycle
    logic [3:0] thr_value;   // programmed threshold
    logic [1:0] babble_d;    // babble count including this check

    assign thr_value = sec_q[SEC_THR_LSB +: 4];
    assign deep_d = deep_wanted(sec_q[SEC_THR_ENABLE], hird_in_use, thr_value);
    assign babble_d = babble_cnt_q + 2'h1;

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    // masks keep reserved bits at zero whatever software writes
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            sec_q <= SEC_RESET;
            pri_q <= PRI_RESET;
            tag_q <= USER_TAG_RESET;
            gpo_q <= GPO_RESET;
        end
        else if (reg_wr)
        begin
            case (reg_addr)
                ADDR_CONTROL_SECONDARY: sec_q <= reg_wdata & SEC_WRITE_MASK;
                ADDR_CONTROL_PRIMARY: pri_q <= reg_wdata & PRI_WRITE_MASK;
                ADDR_USER_TAG: tag_q <= reg_wdata;
                ADDR_GENERAL_PURPOSE_IO: gpo_q <= reg_wdata[31:16];
                default: ;                                                   // unmapped writes dropped
            endcase
        end
    end

    // ----------------------------------------------------------------
    // input synchroniser for the general purpose pins
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            gpi_meta_q <= 16'h0000;
            gpi_q <= 16'h0000;
        end
        else
        begin
            gpi_meta_q <= general_input_port;
            gpi_q <= gpi_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // register reads, data one cycle after the strobe
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            rdata_q <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_CONTROL_SECONDARY: rdata_q <= sec_q;
                ADDR_CORE_IDENTITY: rdata_q <= {CORE_ID, RELEASE_ID};
                ADDR_GENERAL_PURPOSE_IO: rdata_q <= {gpo_q, gpi_q};
                ADDR_USER_TAG: rdata_q <= tag_q;
                ADDR_CONTROL_PRIMARY: rdata_q <= pri_q;
                default: rdata_q <= 32'h0000_0000;                     // unmapped reads zero
            endcase
        end
        else
            rdata_q <= 32'h0000_0000;
    end

    // ----------------------------------------------------------------
    // scheduler controls
    // ----------------------------------------------------------------
    // park controls only matter while hosting, so the three park off flags are gated here; the hs request shape is not
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            sched_q <= '0;
        else
        begin
            sched_q.ss_park_off <= host_mode && sec_q[SEC_SS_PARK_OFF];
            sched_q.hs_park_off <= host_mode && sec_q[SEC_HS_PARK_OFF];
            sched_q.fsls_park_off <= host_mode && sec_q[SEC_FSLS_PARK_OFF];
            sched_q.hs_nak_async_boost <= host_mode && sec_q[SEC_HS_NAK_BOOST];
            sched_q.skip_post_frame_wait <= pri_q[PRI_SKIP_FRAME_WAIT];
            sched_q.sparse_control_schedule <= host_mode && pri_q[PRI_SPARSE_CONTROL];
            sched_q.exit_latency_delta_enable <= host_mode && sec_q[SEC_ELD_ENABLE];
            sched_q.context_check_off <= sec_q[SEC_CTX_CHECK_OFF];
            sched_q.ref_period_ns <= pri_q[PRI_REF_PERIOD_LSB +: 10];
            // one packet at a time lets a slow device nak more often
            if (sec_q[SEC_HS_PARK_OFF])
            begin
                sched_q.hs_packets_per_request <= SINGLE_PACKET;
                sched_q.hs_nak_limit <= SINGLE_NAK_LIMIT;
            end
            else
            begin
                sched_q.hs_packets_per_request <= PARK_PACKETS;
                sched_q.hs_nak_limit <= PARK_NAK_LIMIT;
            end
            // device mode ignores the relaxed reserve
            if (host_mode && pri_q[PRI_BANDWIDTH_85])
                sched_q.periodic_share_pct <= PERIODIC_SHARE_HIGH;
            else
                sched_q.periodic_share_pct <= PERIODIC_SHARE_LOW;
        end
    end

    // ----------------------------------------------------------------
    // l1 signalling toward the phy
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            l1_q <= '0;
        else
        begin
            l1_q.phy_deep_suspend_out <= host_mode && l1_active && deep_d;
            l1_q.phy_sleep_out <= host_mode && l1_active && !deep_d;
            // overload suits phys that stop the port clock in sleep
            if (sec_q[SEC_COMMON_FOLLOWS_SLEEP])
                l1_q.phy_suspend_common_out <= host_mode && l1_active && !deep_d;
            else
                l1_q.phy_suspend_common_out <= host_mode && l1_active && deep_d;
        end
    end

    // ----------------------------------------------------------------
    // wait after each frame start
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            wait_cnt_q <= 8'h00;
            first_ok_q <= 1'b0;
        end
        else
        begin
            if (frame_start && !pri_q[PRI_SKIP_FRAME_WAIT])
                wait_cnt_q <= 8'(FRAME_WAIT_CYC - 1);
            else if (wait_cnt_q != 8'h00)
                wait_cnt_q <= wait_cnt_q - 8'h01;
            // skipping the wait also cancels one already running
            if (pri_q[PRI_SKIP_FRAME_WAIT])
                first_ok_q <= 1'b1;
            else
                first_ok_q <= !frame_start && (wait_cnt_q == 8'h00);
        end
    end

    // ----------------------------------------------------------------
    // babble filter
    // ----------------------------------------------------------------
    // a clean check breaks the run, so only consecutive hits count
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            babble_cnt_q <= 2'h0;
            babble_dis_q <= 1'b0;
        end
        else
        begin
            babble_dis_q <= 1'b0;
            if (babble_check)
            begin
                if (!babble_seen)
                    babble_cnt_q <= 2'h0;
                else if (babble_d >= babble_needed(host_mode && sec_q[SEC_BABBLE_FILTER]))
                begin
                    babble_cnt_q <= 2'h0;
                    babble_dis_q <= 1'b1;
                end
                else
                    babble_cnt_q <= babble_d;
            end
        end
    end

    // ----------------------------------------------------------------
    // context checks and address assignment
    // ----------------------------------------------------------------
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
            ctx_err_q <= 1'b0;
        else
            ctx_err_q <= ctx_check_req && ctx_fields_bad && !sec_q[SEC_CTX_CHECK_OFF];
    end

    // in compliance mode addresses run 1 to 127 and wrap, zero is never handed out; otherwise the slot id is handed out
    always_ff @(posedge ref_clk or posedge rst)
    begin
        if (rst)
        begin
            next_addr_q <= 7'h01;
            dev_addr_q <= 8'h00;
            addr_valid_q <= 1'b0;
        end
        else
        begin
            addr_valid_q <= address_cmd;
            if (address_cmd)
            begin
                if (pri_q[PRI_ADDR_COMPLIANCE])
                begin
                    dev_addr_q <= {1'b0, next_addr_q};
                    next_addr_q <= (next_addr_q == 7'h7F) ? 7'h01 : next_addr_q + 7'h01;
                end
                else
                    dev_addr_q <= slot_id;
            end
        end
    end

    // ----------------------------------------------------------------
    // outputs
    // ----------------------------------------------------------------
    assign reg_rdata = rdata_q;
    assign sched_ctrl = sched_q;
    assign l1_phy = l1_q;
    assign first_packet_ok = first_ok_q;
    assign babble_port_disable = babble_dis_q;
    assign ctx_param_error = ctx_err_q;
    assign addr_valid = addr_valid_q;
    assign device_address = dev_addr_q;
    assign general_output_port = gpo_q;

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);
    a_ss_park_gate: assert property (sched_q.ss_park_off |-> $past(host_mode))
        else $error("superspeed park off outside host mode");
    a_park_packets: assert property (!rst && !sec_q[SEC_HS_PARK_OFF] |=> sched_q.hs_packets_per_request == PARK_PACKETS && sched_q.hs_nak_limit == PARK_NAK_LIMIT)
        else $error("park mode request shape wrong");
    a_single_packets: assert property ($past(sec_q[SEC_HS_PARK_OFF]) |-> sched_q.hs_nak_limit == 4'hC && sched_q.hs_packets_per_request == 3'h1)
        else $error("single packet shape wrong");
    a_deep_suspend: assert property (!rst && host_mode && l1_active && sec_q[8] && hird_in_use >= sec_q[7:4] |=> l1_q.phy_deep_suspend_out && !l1_q.phy_sleep_out)
        else $error("deep suspend not asserted");
    a_shallow_sleep: assert property (host_mode && l1_active && (!sec_q[8] || hird_in_use < sec_q[7:4]) |=> l1_q.phy_sleep_out && !l1_q.phy_deep_suspend_out)
        else $error("sleep not asserted");
    a_common_follow: assert property (##1 $past(sec_q[SEC_COMMON_FOLLOWS_SLEEP]) |-> l1_q.phy_suspend_common_out == l1_q.phy_sleep_out)
        else $error("suspend common differs from sleep");
    a_ctx_error: assert property (ctx_check_req && ctx_fields_bad |=> ctx_err_q == !$past(sec_q[SEC_CTX_CHECK_OFF]))
        else $error("parameter error reporting wrong");
    a_babble_three: assert property (host_mode && sec_q[0] && babble_check && babble_seen && babble_cnt_q == 2'h0 |=> !babble_dis_q)
        else $error("port disabled on first babble");
    a_frame_wait: assert property ($rose(frame_start) && !pri_q[PRI_SKIP_FRAME_WAIT] |=> !first_ok_q [*8])
        else $error("packet allowed inside frame wait");
    a_gpio_read: assert property (reg_rd && reg_addr == ADDR_GENERAL_PURPOSE_IO |=> reg_rdata[15:0] == $past(gpi_q) && reg_rdata[31:16] == general_output_port)
        else $error("gpio read mismatch");
    a_reserved_zero: assert property (reg_rd && reg_addr == ADDR_CONTROL_SECONDARY |=> (reg_rdata & ~SEC_WRITE_MASK) == 32'h0)
        else $error("reserved bits read nonzero");
    a_slot_address: assert property (address_cmd && !pri_q[15] |=> addr_valid && device_address == $past(slot_id))
        else $error("address not slot id");
    a_share_value: assert property (!rst |=> sched_q.periodic_share_pct == ($past(host_mode && pri_q[PRI_BANDWIDTH_85]) ? PERIODIC_SHARE_HIGH : PERIODIC_SHARE_LOW))
        else $error("periodic share wrong for mode");

    c_deep_entry: cover property (l1_q.phy_deep_suspend_out);
    c_babble_drop: cover property (babble_dis_q && sec_q[0]);
    c_ctx_error: cover property (ctx_err_q);
    c_addr_inc: cover property (addr_valid && pri_q[15]);

endmodule // usb3_tuning_regs
